// *** dv/lowalert_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// Port checker
// ----
module lowalert_chk
    import lowalert_pkg::*;
#(
    parameter int EXTRA_CYC = CANCEL_EXTRA_CYC
) (
    // Watched ports
    input wire logic         CLK_I,
    input wire logic         NRST_I,
    input wire reg_req_t     REQ_I,
    input wire logic [7:0]   RDATA_O,
    input wire logic         RVALID_O,
    input wire logic         CONV_DONE_I,
    input wire conv_result_t CONV_I,
    input wire logic         CONV_START_I,
    input wire logic [6:0]   CANCEL_EN_O,
    input wire logic [4:0]   IDEALITY_CODE_O,
    input wire logic         EXTEND_BUSY_O,
    input wire logic         ALERT_N_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    // Causes; signed compare because limits may be negative
    wire logic rd_st = REQ_I.rd && REQ_I.addr == LOW_ALERT_STATUS_ADDR;
    wire logic below = CONV_DONE_I && $signed(CONV_I.temp) < $signed(CONV_I.low_limit);
    wire logic ext   = CONV_START_I && CONV_I.channel != 3'h0 && CANCEL_EN_O[CONV_I.channel - 3'h1];

    rd_answer_a: assert property (REQ_I.rd |=> RVALID_O) else $error("no read answer");
    flag_set_a: assert property (below |=> !ALERT_N_O) else $error("alert not raised");
    flag_hold_a: assert property (!ALERT_N_O && !rd_st |=> !ALERT_N_O)
        else $error("alert dropped");
    read_clear_a: assert property (rd_st && !below |=> ALERT_N_O) else $error("alert kept");
    cancel_top_a: assert property (RVALID_O && $past(REQ_I.addr) == SERIES_RES_CANCEL_ADDR
        |-> !RDATA_O[7]) else $error("cancel bit 7 set");
    code_top_a: assert property (RVALID_O && $past(REQ_I.addr) == DIODE_IDEALITY_CODE_ADDR
        |-> RDATA_O[7:5] == 3'h0) else $error("code upper bits set");
    cancel_copy_a: assert property (REQ_I.wr && REQ_I.addr == SERIES_RES_CANCEL_ADDR
        |-> ##2 CANCEL_EN_O == $past(REQ_I.wdata[6:0], 2)) else $error("cancel copy wrong");
    local_code_a: assert property (CONV_I.channel == LOCAL_CHANNEL
        |=> IDEALITY_CODE_O == IDEALITY_DEFAULT_CODE) else $error("local code wrong");
    ext_run_a: assert property (ext |=> EXTEND_BUSY_O [*8]) else $error("extension short");
    ext_idle_a: assert property (!EXTEND_BUSY_O && !CONV_START_I |=> !EXTEND_BUSY_O)
        else $error("extension unprompted");
endmodule : lowalert_chk
`default_nettype wire

// *** dv/lowalert_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// Register host
// ----
module lowalert_host_model
    import lowalert_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output var  reg_req_t   req_o
);
    initial req_o = '0;
    // One byte access; released fields flipped so stale values never look valid
    task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
        @(negedge clk_i);
        req_o = '{w, !w, a, d};
        @(negedge clk_i);
        req_o = '{1'b0, 1'b0, ~a, ~d};
        q = rvalid_i ? rdata_i : 8'hxx;
    endtask : acc
endmodule : lowalert_host_model
`default_nettype wire

// *** dv/tb_lowalert_comp_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench
// ----
module tb_lowalert_comp_regs
    import lowalert_pkg::*;
;
    localparam int EXT = 20;
    logic         clk, rst_n, done, start, rvalid, busy, alert_n;
    conv_result_t conv;
    reg_req_t     req;
    logic [7:0]   rdata, q;
    logic [6:0]   cen;
    logic [4:0]   code;
    int           n_fail, num_checks, cyc;

    lowalert_host_model host_u (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
    lowalert_comp_regs #(.EXTRA_CYC(EXT)) dut_u (.CLK_I(clk), .NRST_I(rst_n), .REQ_I(req),
        .RDATA_O(rdata), .RVALID_O(rvalid), .CONV_DONE_I(done), .CONV_I(conv),
        .CONV_START_I(start), .CANCEL_EN_O(cen), .IDEALITY_CODE_O(code),
        .EXTEND_BUSY_O(busy), .ALERT_N_O(alert_n));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [7:0] seen, exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, d);
        host_u.acc(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, exp);
        host_u.acc(1'b0, a, 8'h00, q);
        chk(q, exp, "rdata");
    endtask : rd
    // Below case uses negative temp, so an unsigned compare would miss it
    task automatic cv(input logic [2:0] ch, input logic lo);
        @(negedge clk);
        conv = lo ? '{ch, 11'h7f0, 11'h010} : '{ch, 11'h010, 11'h7f0};
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
    endtask : cv
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    // Hang guard, far above the expected 170 or so cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            finish_test();
        end
    end

    initial begin
        {rst_n, done, start, conv, n_fail, num_checks, cyc} = '0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        rd(LOW_ALERT_STATUS_ADDR, 8'h00);
        rd(SERIES_RES_CANCEL_ADDR, 8'h00);
        rd(DIODE_IDEALITY_CODE_ADDR, 8'h09);
        rd(8'h50, 8'h00);
        wr(SERIES_RES_CANCEL_ADDR, 8'hff);
        rd(SERIES_RES_CANCEL_ADDR, 8'h7f);
        wr(SERIES_RES_CANCEL_ADDR, 8'h00);
        rd(SERIES_RES_CANCEL_ADDR, 8'h00);
        wr(DIODE_IDEALITY_CODE_ADDR, 8'hff);
        rd(DIODE_IDEALITY_CODE_ADDR, 8'h1f);
        for (int c = 0; c < 8; c++) begin
            cv(3'(c), 1'b0);
            chk({7'h0, alert_n}, 8'h01, "alert idle");
            cv(3'(c), 1'b1);
            chk({7'h0, alert_n}, 8'h00, "alert");
            wr(LOW_ALERT_STATUS_ADDR, 8'h00);
            rd(LOW_ALERT_STATUS_ADDR, c == 0 ? 8'h40 : c == 7 ? 8'h80 : 8'h01 << (c - 1));
            rd(LOW_ALERT_STATUS_ADDR, 8'h00);
        end
        // Event and clearing read in one cycle: the new flag must survive
        fork
            rd(LOW_ALERT_STATUS_ADDR, 8'h00);
            cv(3'h3, 1'b1);
        join
        rd(LOW_ALERT_STATUS_ADDR, 8'h04);
        chk({7'h0, alert_n}, 8'h01, "alert cleared");
        wr(IDEALITY_SELECT_ADDR, 8'h02);
        for (int c = 0; c < 3; c++) begin
            conv.channel = 3'(c);
            repeat (2) @(negedge clk);
            chk({3'h0, code}, c == 2 ? 8'h1f : 8'h09, "ideality");
        end
        wr(SERIES_RES_CANCEL_ADDR, 8'h04);
        @(negedge clk);
        chk({1'b0, cen}, 8'h04, "cancel out");
        for (int c = 1; c < 4; c += 2) begin
            @(negedge clk);
            {conv.channel, start} = {3'(c), 1'b1};
            @(negedge clk);
            start = 1'b0;
            @(negedge clk);
            chk({7'h0, busy}, c == 3 ? 8'h01 : 8'h00, "busy");
        end
        repeat (EXT - 1) @(negedge clk);
        chk({7'h0, busy}, 8'h01, "busy held");
        repeat (1) @(negedge clk);
        chk({7'h0, busy}, 8'h00, "busy end");
        // Mid-run reset with a flag and an enable set
        cv(3'h1, 1'b1);
        rst_n = 1'b0;
        @(negedge clk);
        chk({cen, alert_n}, 8'h01, "reset outputs");
        rst_n = 1'b1;
        rd(LOW_ALERT_STATUS_ADDR, 8'h00);
        rd(SERIES_RES_CANCEL_ADDR, 8'h00);
        rd(DIODE_IDEALITY_CODE_ADDR, 8'h09);
        finish_test();
    end
endmodule : tb_lowalert_comp_regs

bind lowalert_comp_regs lowalert_chk #(.EXTRA_CYC(EXTRA_CYC)) chk_u (.CLK_I(CLK_I),
    .NRST_I(NRST_I), .REQ_I(REQ_I), .RDATA_O(RDATA_O), .RVALID_O(RVALID_O),
    .CONV_DONE_I(CONV_DONE_I), .CONV_I(CONV_I), .CONV_START_I(CONV_START_I),
    .CANCEL_EN_O(CANCEL_EN_O), .IDEALITY_CODE_O(IDEALITY_CODE_O),
    .EXTEND_BUSY_O(EXTEND_BUSY_O), .ALERT_N_O(ALERT_N_O));
`default_nettype wire

// *** shared/lowalert_pkg.sv ***
`default_nettype none
package lowalert_pkg;

    // ------------------------------------------------------------
    // Register map (byte offsets on the internal register port)
    // ------------------------------------------------------------
    localparam logic [7:0] LOW_ALERT_STATUS_ADDR    = 8'h47;
    localparam logic [7:0] SERIES_RES_CANCEL_ADDR   = 8'h4a;
    localparam logic [7:0] DIODE_IDEALITY_CODE_ADDR = 8'h4b;
    localparam logic [7:0] IDEALITY_SELECT_ADDR     = 8'h4c;

    // ------------------------------------------------------------
    // Reset values and fields
    // ------------------------------------------------------------
    localparam logic [7:0] LOW_ALERT_STATUS_RST  = 8'h00;
    localparam logic [7:0] SERIES_RES_CANCEL_RST = 8'h00;
    localparam logic [4:0] IDEALITY_CODE_RST     = 5'h09;
    localparam logic [7:0] IDEALITY_SELECT_RST   = 8'h00;
    localparam logic [4:0] IDEALITY_DEFAULT_CODE = 5'h09;
    localparam int         IDEALITY_CODE_W       = 5;
    localparam int         CANCEL_MASK_W         = 7;
    localparam int         LOCAL_BIT             = 6;
    localparam int         CHANNEL_W             = 3;
    localparam logic [2:0] LOCAL_CHANNEL         = 3'h0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ           = 20_000_000;
    localparam int CANCEL_EXTRA_MS  = 125;
    localparam int CANCEL_EXTRA_CYC = CLK_HZ / 1000 * CANCEL_EXTRA_MS;

    // Conversion result handed in by the measurement sequencer
    typedef struct packed {
        logic [2:0]  channel;
        logic [10:0] temp;
        logic [10:0] low_limit;
    } conv_result_t;

    // Register access from the serial interface
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage : lowalert_pkg
`default_nettype wire

// *** src/cancel_extend_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module cancel_extend_timer
    import lowalert_pkg::*;
#(
    parameter int EXTRA_CYC = CANCEL_EXTRA_CYC
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic start_i,
    output var  logic busy_o
);
    localparam int CNT_W = $clog2(EXTRA_CYC + 1);

    logic [CNT_W-1:0] cnt_r;

    // ------------------------------------------------------------
    // Extra settling time
    // ------------------------------------------------------------
    // Counts the added conversion time; start restarts it
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r <= '0;
        end else if (start_i) begin
            cnt_r <= CNT_W'(EXTRA_CYC);
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    assign busy_o = (cnt_r != '0);
endmodule : cancel_extend_timer
`default_nettype wire

// *** src/lowalert_comp_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Remote below low limit sets its bit
// - Local below low limit sets bit 6
// - Default ideality code is 1.008
// - Five-bit ideality code, upper bits ignored
// - Per-channel select default or programmed ideality
// - Cancel enables bits 0-6, reset zero
// - Write one enables, zero disables cancellation
// - Cancellation adds 125 ms to remote conversion
// - Read clears flags; persistent fault sets again
// - Alert output low while any flag set
module lowalert_comp_regs
    import lowalert_pkg::*;
#(
    parameter int EXTRA_CYC = CANCEL_EXTRA_CYC
) (
    // Clock and reset
    input  wire logic         CLK_I,
    input  wire logic         NRST_I,
    // Register port from the serial interface
    input  wire reg_req_t     REQ_I,
    output var  logic [7:0]   RDATA_O,
    output var  logic         RVALID_O,
    // Conversion results from the sequencer
    input  wire logic         CONV_DONE_I,
    input  wire conv_result_t CONV_I,
    // Sequencer control
    input  wire logic         CONV_START_I,
    output var  logic [6:0]   CANCEL_EN_O,
    output var  logic [4:0]   IDEALITY_CODE_O,
    output var  logic         EXTEND_BUSY_O,
    // Alert pin
    output var  logic         ALERT_N_O
);

    // Register contents
    wire logic [7:0]            status_r;
    logic [CANCEL_MASK_W-1:0]   cancel_r;
    logic [IDEALITY_CODE_W-1:0] ideal_code_r;
    logic [7:0]                 ideal_sel_r;
    // Flag next state and channel decode
    wire logic [7:0]            status_nxt;
    wire logic [7:0]            set_vec;
    logic [2:0]                 bit_idx;
    logic [2:0]                 rem_idx;
    logic                       is_remote;
    logic                       below;
    logic                       clr_rd;
    // Register port decode
    logic                       wr_cancel;
    logic                       wr_code;
    logic                       wr_sel;
    logic [7:0]                 rdata_nxt;
    // Sequencer side
    logic                       use_prog;
    logic                       ext_start;
    logic                       ext_busy;

    // ------------------------------------------------------------
    // Low-alert flags
    // ------------------------------------------------------------
    // Map channel to status bit: local on 6, remote 1-6 on 0-5, 7 on 7
    always_comb begin
        bit_idx = 3'(LOCAL_BIT);
        if (CONV_I.channel == 3'h7) begin
            bit_idx = 3'h7;
        end else if (CONV_I.channel != LOCAL_CHANNEL) begin
            bit_idx = CONV_I.channel - 3'h1;
        end
    end

    // Remote channel n uses bit n-1 of the per-channel registers
    assign is_remote = (CONV_I.channel != LOCAL_CHANNEL);
    assign rem_idx   = CONV_I.channel - 3'h1;

    // Signed compare; result strictly below the limit trips the flag
    assign below  = $signed(CONV_I.temp) < $signed(CONV_I.low_limit);
    assign clr_rd = REQ_I.rd && (REQ_I.addr == LOW_ALERT_STATUS_ADDR);

    // One cell per status bit; only the converted channel's cell can set
    for (genvar b = 0; b < 8; b++) begin : g_flag
        logic flag_r;

        // Set beats the read-clear so a same-cycle event is not lost
        assign set_vec[b]    = CONV_DONE_I && below && (bit_idx == 3'(b));
        assign status_nxt[b] = (flag_r && !clr_rd) || set_vec[b];

        // A cleared bit returns on the next failing compare
        always_ff @(posedge CLK_I or negedge NRST_I) begin
            if (!NRST_I) begin
                flag_r <= LOW_ALERT_STATUS_RST[b];
            end else begin
                flag_r <= status_nxt[b];
            end
        end

        assign status_r[b] = flag_r;
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Write strobes; the status register and unmapped addresses ignore writes
    assign wr_cancel = REQ_I.wr && (REQ_I.addr == SERIES_RES_CANCEL_ADDR);
    assign wr_code   = REQ_I.wr && (REQ_I.addr == DIODE_IDEALITY_CODE_ADDR);
    assign wr_sel    = REQ_I.wr && (REQ_I.addr == IDEALITY_SELECT_ADDR);

    // Cancellation enables; bit 7 is dropped
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cancel_r <= SERIES_RES_CANCEL_RST[CANCEL_MASK_W-1:0];
        end else if (wr_cancel) begin
            cancel_r <= REQ_I.wdata[CANCEL_MASK_W-1:0];
        end
    end

    // Ideality code; only the low five bits are kept
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ideal_code_r <= IDEALITY_CODE_RST;
        end else if (wr_code) begin
            ideal_code_r <= REQ_I.wdata[IDEALITY_CODE_W-1:0];
        end
    end

    // Per-channel ideality select, bit n-1 for remote channel n
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ideal_sel_r <= IDEALITY_SELECT_RST;
        end else if (wr_sel) begin
            ideal_sel_r <= REQ_I.wdata;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Read mux; unmapped reads give zero, unused top bits of cancel and code read zero, select bit 7 reads back as written
    always_comb begin
        unique case (REQ_I.addr)
            LOW_ALERT_STATUS_ADDR:    rdata_nxt = status_r;
            SERIES_RES_CANCEL_ADDR:   rdata_nxt = {1'b0, cancel_r};
            DIODE_IDEALITY_CODE_ADDR: rdata_nxt = {3'h0, ideal_code_r};
            IDEALITY_SELECT_ADDR:     rdata_nxt = ideal_sel_r;
            default:                  rdata_nxt = 8'h00;
        endcase
    end

    // Answer strobe, one cycle after each read request
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            RVALID_O <= 1'b0;
        end else begin
            RVALID_O <= REQ_I.rd;
        end
    end

    // Returns old status on the clearing read, so no flag is lost unseen
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            RDATA_O <= 8'h00;
        end else begin
            RDATA_O <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Sequencer outputs
    // ------------------------------------------------------------
    // Extension starts only for a remote channel with cancellation on
    always_comb begin
        ext_start = 1'b0;
        if (CONV_START_I && is_remote) begin
            ext_start = cancel_r[rem_idx];
        end
    end

    // Programmed code only where the channel's select bit is set
    always_comb begin
        use_prog = 1'b0;
        if (is_remote) begin
            use_prog = ideal_sel_r[rem_idx];
        end
    end

    cancel_extend_timer #(
        .EXTRA_CYC (EXTRA_CYC)
    ) u_ext (
        .clk_i   (CLK_I),
        .nrst_i  (NRST_I),
        .start_i (ext_start),
        .busy_o  (ext_busy)
    );

    // Registered copies for the sequencer; ideality picked per channel
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            CANCEL_EN_O     <= 7'h00;
            IDEALITY_CODE_O <= IDEALITY_DEFAULT_CODE;
            EXTEND_BUSY_O   <= 1'b0;
        end else begin
            CANCEL_EN_O   <= cancel_r;
            EXTEND_BUSY_O <= ext_busy || ext_start;
            if (use_prog) begin
                IDEALITY_CODE_O <= ideal_code_r;
            end else begin
                IDEALITY_CODE_O <= IDEALITY_DEFAULT_CODE;
            end
        end
    end

    // ------------------------------------------------------------
    // Alert pin
    // ------------------------------------------------------------
    // Driven from next state so the pin tracks the flags with no extra lag
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ALERT_N_O <= 1'b1;
        end else begin
            ALERT_N_O <= ~(|status_nxt);
        end
    end

endmodule : lowalert_comp_regs
`default_nettype wire
